// ===== core/byte_add_subtract_alu.sv
// Byte add, add-with-carry and subtract datapath with its instruction sequencer.
// Assumes the decoder offers bytes with a valid strobe and memory answers in the read cycle.
// Summary of operation
// - Opcode 86 adds the byte at pointer_pair address to accumulator.
// - Pointer-pair add takes two machine cycles: fetch 4, read 3 states.
// - Prefix DD before 86 adds byte at first_index_pair plus signed displacement.
// - Prefix FD uses second_index_pair plus displacement instead.
// - Indexed forms take five machine cycles: 4, 4, 3, 5, 3 states.
// - Immediate and pointer-pair add-with-carry and subtract take 4 plus 3 states.
// - Register add-with-carry and subtract finish in one 4-state cycle.
// - Add-with-carry adds operand and carry flag; opcodes CE, 8E, prefixed 8E.
// - Register select: B C D E H L memory accumulator as codes 0 to 7.
// - Subtract stores difference; opcodes D6, 96, prefixed 96, 10010rrr.
// - Sign flag copies result bit 7.
// - Zero flag set when result is zero.
// - Additions set half-carry on carry out of bit 3.
// - Additions set carry on carry out of bit 7 and clear add/subtract flag.
// - Parity/overflow flag shows signed overflow.
// - Subtract sets half-carry on borrow from bit 4.
// - Subtract sets carry on borrow and sets add/subtract flag.
// - Opcode C6 adds the following byte, in 4 plus 3 states.
`timescale 1ns/1ps
`default_nettype none
`include "byte_alu_consts.svh"

module byte_add_subtract_alu (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Instruction byte stream
	input wire logic code_valid,
	input wire logic [7:0] code_byte,
	output logic code_take,
	// Register file view
	input wire logic [7:0] reg_b,
	input wire logic [7:0] reg_c,
	input wire logic [7:0] reg_d,
	input wire logic [7:0] reg_e,
	input wire logic [7:0] reg_h,
	input wire logic [7:0] reg_l,
	input wire logic [15:0] first_index_pair,
	input wire logic [15:0] second_index_pair,
	// Operand memory
	output logic mem_rd,
	output logic [15:0] mem_addr,
	input wire logic [7:0] mem_data,
	// Results
	output logic [7:0] acc_out,
	output logic [7:0] flags_out,
	output logic done,
	output logic busy
);

	// ----------------------------------------
	// Sequencer states, one per machine cycle
	// ----------------------------------------
	typedef enum logic [5:0] {
		st_fetch = 6'b000001,
		st_pfx = 6'b000010,
		st_disp = 6'b000100,
		st_addr = 6'b001000,
		st_read = 6'b010000,
		st_imm = 6'b100000
	} state_e;

	// Register-select decoding, shared by the operand mux.
	function automatic logic [7:0] reg_pick(input logic [2:0] sel, input logic [7:0] b,
			input logic [7:0] c, input logic [7:0] d, input logic [7:0] e,
			input logic [7:0] h, input logic [7:0] l, input logic [7:0] a);
		logic [7:0] v;
		v = a;
		case (sel)
			`RSEL_B: v = b;
			`RSEL_C: v = c;
			`RSEL_D: v = d;
			`RSEL_E: v = e;
			`RSEL_H: v = h;
			`RSEL_L: v = l;
			default: v = a;
		endcase
		return v;
	endfunction : reg_pick

	state_e st_q, st_d;
	byte_alu_pkg::alu_op_e op_q, op_d;
	logic idx2_q, idx2_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0] acc_q, acc_d;
	logic [7:0] flags_q, flags_d;
	logic done_q, done_d;
	logic rd_q, rd_d;
	logic take_q, take_d;
	logic load;
	logic [2:0] len;
	logic last;
	logic [7:0] operand;
	logic [7:0] alu_res;
	logic [7:0] alu_flags;
	logic commit;
	logic [15:0] base;
	byte_alu_pkg::alu_op_e alu_op;

	// Clock-state counter for each machine cycle.
	byte_alu_cycles u_cycles (
		.sys_clk(sys_clk),
		.rst(rst),
		.load(load),
		.len(len),
		.last(last)
	);

	// The register form decodes and commits in one cycle, before op_q holds its
	// operation, so the flag unit is handed the freshly decoded one in that cycle.
	always_comb begin
		alu_op = op_q;
		if (st_q == st_fetch && busy && last) begin
			alu_op = byte_alu_pkg::alu_op_e'(code_byte[4:3]);
		end
	end

	// Arithmetic and flag generation.
	byte_alu_flags u_flags (
		.acc(acc_q),
		.operand(operand),
		.carry_input(flags_q[`FLAG_C]),
		.op(alu_op),
		.result(alu_res),
		.flags(alu_flags)
	);

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	// Each state is one machine cycle; the counter paces its clock states and the
	// byte is taken at the last state so the decoder has the whole cycle to present it.
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		idx2_d = idx2_q;
		addr_d = addr_q;
		acc_d = acc_q;
		flags_d = flags_q;
		done_d = 1'b0;
		rd_d = 1'b0;
		take_d = 1'b0;
		load = 1'b0;
		len = `T_FETCH;
		operand = mem_data;
		commit = 1'b0;
		base = idx2_q ? second_index_pair : first_index_pair;
		if (st_q == st_fetch && !busy && code_valid) begin
			load = 1'b1;
			len = `T_FETCH;
		end
		case (st_q)
			st_fetch: begin
				if (busy && last && code_valid) begin
					take_d = 1'b1;
					if (code_byte == `OP_PFX_FIRST || code_byte == `OP_PFX_SECOND) begin
						idx2_d = (code_byte == `OP_PFX_SECOND);
						load = 1'b1;
						len = `T_FETCH;
						st_d = st_pfx;
					end else if (code_byte == `OP_ADD_MEM || code_byte == `OP_ADC_MEM ||
							code_byte == `OP_SUB_MEM) begin
						op_d = byte_alu_pkg::alu_op_e'(code_byte[4:3]);
						addr_d = {reg_h, reg_l};
						rd_d = 1'b1;
						load = 1'b1;
						len = `T_READ;
						st_d = st_read;
					end else if (code_byte == `OP_ADD_IMM || code_byte == `OP_ADC_IMM ||
							code_byte == `OP_SUB_IMM) begin
						op_d = byte_alu_pkg::alu_op_e'(code_byte[4:3]);
						load = 1'b1;
						len = `T_READ;
						st_d = st_imm;
					end else if (code_byte[7:3] == `OP_ADD_REG_HI ||
							code_byte[7:3] == `OP_ADC_REG_HI ||
							code_byte[7:3] == `OP_SUB_REG_HI) begin
						op_d = byte_alu_pkg::alu_op_e'(code_byte[4:3]);
						commit = 1'b1;
					end
				end
			end
			st_pfx: begin
				if (last && code_valid) begin
					take_d = 1'b1;
					if (code_byte == `OP_ADD_MEM || code_byte == `OP_ADC_MEM ||
							code_byte == `OP_SUB_MEM) begin
						op_d = byte_alu_pkg::alu_op_e'(code_byte[4:3]);
						load = 1'b1;
						len = `T_READ;
						st_d = st_disp;
					end else begin
						st_d = st_fetch;
					end
				end
			end
			st_disp: begin
				if (last && code_valid) begin
					take_d = 1'b1;
					addr_d = base + {{8{code_byte[7]}}, code_byte};
					load = 1'b1;
					len = `T_ADDR;
					st_d = st_addr;
				end
			end
			st_addr: begin
				if (last) begin
					rd_d = 1'b1;
					load = 1'b1;
					len = `T_READ;
					st_d = st_read;
				end
			end
			st_read: begin
				rd_d = !last;
				operand = mem_data;
				if (last) begin
					commit = 1'b1;
				end
			end
			st_imm: begin
				operand = code_byte;
				if (last && code_valid) begin
					take_d = 1'b1;
					commit = 1'b1;
				end
			end
			default: st_d = st_fetch;
		endcase
		if (st_q == st_fetch && busy && last && code_valid && commit) begin
			operand = reg_pick(code_byte[2:0], reg_b, reg_c, reg_d, reg_e, reg_h, reg_l,
				acc_q);
		end
		if (commit) begin
			acc_d = alu_res;
			flags_d = alu_flags;
			done_d = 1'b1;
			st_d = st_fetch;
		end
	end

	// Busy tells an idle fetch from a fetch in progress, since both wait in st_fetch.
	logic busy_q, busy_d;

	// Busy spans from the start of a fetch cycle to the commit, or to the cycle that refuses an unknown or prefixed byte.
	always_comb begin
		busy_d = busy_q;
		if (st_q == st_fetch && !busy_q && code_valid) begin
			busy_d = 1'b1;
		end else if (commit || (st_q == st_fetch && busy_q && last && code_valid &&
				st_d == st_fetch)) begin
			busy_d = 1'b0;
		end else if (st_q == st_pfx && last && code_valid && st_d == st_fetch) begin
			// A prefix before any byte but 86, 8E or 96 aborts; without this the next byte
			// would be decoded at once, skipping its fetch states.
			busy_d = 1'b0;
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q <= st_fetch;
			op_q <= byte_alu_pkg::op_add;
			idx2_q <= 1'b0;
			addr_q <= 16'h0000;
			acc_q <= `ACC_RESET;
			flags_q <= `FLAGS_RESET;
			done_q <= 1'b0;
			rd_q <= 1'b0;
			take_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			idx2_q <= idx2_d;
			addr_q <= addr_d;
			acc_q <= acc_d;
			flags_q <= flags_d;
			done_q <= done_d;
			rd_q <= rd_d;
			take_q <= take_d;
			busy_q <= busy_d;
		end
	end

	// Outputs come straight from the registers above.
	always_comb begin
		busy = busy_q;
		acc_out = acc_q;
		flags_out = flags_q;
		done = done_q;
		mem_rd = rd_q;
		mem_addr = addr_q;
		code_take = take_q;
	end

endmodule : byte_add_subtract_alu
`default_nettype wire

// ===== core/byte_alu_consts.svh
// Constants of the byte add/subtract datapath: opcodes, codes, flag positions, timing.
// Assumes inclusion by its bare name from the design modules.
`ifndef BYTE_ALU_CONSTS_SVH
`define BYTE_ALU_CONSTS_SVH

// ----------------------------------------
// Opcode and prefix bytes
// ----------------------------------------
`define OP_PFX_FIRST 8'hdd
`define OP_PFX_SECOND 8'hfd
`define OP_ADD_MEM 8'h86
`define OP_ADD_IMM 8'hc6
`define OP_ADC_MEM 8'h8e
`define OP_ADC_IMM 8'hce
`define OP_SUB_MEM 8'h96
`define OP_SUB_IMM 8'hd6
`define OP_ADD_REG_HI 5'h10
`define OP_ADC_REG_HI 5'h11
`define OP_SUB_REG_HI 5'h12

// ----------------------------------------
// Register-select codes
// ----------------------------------------
`define RSEL_B 3'h0
`define RSEL_C 3'h1
`define RSEL_D 3'h2
`define RSEL_E 3'h3
`define RSEL_H 3'h4
`define RSEL_L 3'h5
`define RSEL_MEM 3'h6
`define RSEL_A 3'h7

// ----------------------------------------
// Flag bit positions in the flag byte
// ----------------------------------------
`define FLAG_C 0
`define FLAG_N 1
`define FLAG_PV 2
`define FLAG_H 4
`define FLAG_Z 6
`define FLAG_S 7

// ----------------------------------------
// Machine-cycle lengths in clock states
// ----------------------------------------
`define T_FETCH 3'd4
`define T_READ 3'd3
`define T_ADDR 3'd5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACC_RESET 8'h00
`define FLAGS_RESET 8'h00

`endif

// ===== core/byte_alu_pkg.sv
// Types shared by the byte add/subtract datapath modules.
// Assumes the constants header sits beside it.
package byte_alu_pkg;

	// Arithmetic operation selected by the opcode.
	typedef enum logic [1:0] {
		op_add = 2'h0,
		op_adc = 2'h1,
		op_sub = 2'h2
	} alu_op_e;

	// Operand source of the instruction.
	typedef enum logic [1:0] {
		src_reg = 2'h0,
		src_imm = 2'h1,
		src_ptr = 2'h2,
		src_idx = 2'h3
	} src_e;

endpackage : byte_alu_pkg

// ===== core/byte_alu_flags.sv
// Eight-bit adder/subtractor with the six condition flags.
// Assumes operands and carry come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "byte_alu_consts.svh"

module byte_alu_flags (
	// Operands
	input wire logic [7:0] acc,
	input wire logic [7:0] operand,
	input wire logic carry_input,
	input wire byte_alu_pkg::alu_op_e op,
	// Results
	output logic [7:0] result,
	output logic [7:0] flags
);

	logic sub;
	logic cin;
	logic [7:0] opx;
	logic [4:0] low;
	logic [8:0] full;

	// Subtraction adds the inverted operand with inverted carry so one adder serves both.
	always_comb begin
		sub = (op == byte_alu_pkg::op_sub);
		cin = (op == byte_alu_pkg::op_adc) ? carry_input : 1'b0;
		opx = sub ? ~operand : operand;
		low = {1'b0, acc[3:0]} + {1'b0, opx[3:0]} + {4'h0, cin ^ sub};
		full = {1'b0, acc} + {1'b0, opx} + {8'h00, cin ^ sub};
		result = full[7:0];
		flags = 8'h00;
		flags[`FLAG_S] = full[7];
		flags[`FLAG_Z] = (full[7:0] == 8'h00);
		flags[`FLAG_H] = low[4] ^ sub;
		flags[`FLAG_PV] = (acc[7] == opx[7]) && (full[7] != acc[7]);
		flags[`FLAG_N] = sub;
		flags[`FLAG_C] = full[8] ^ sub;
	end

endmodule : byte_alu_flags
`default_nettype wire

// ===== core/byte_alu_cycles.sv
// Clock-state counter that marks the end of each machine cycle.
// Assumes start pulses only while the sequencer is idle or finishing.
`timescale 1ns/1ps
`default_nettype none
`include "byte_alu_consts.svh"

module byte_alu_cycles (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control
	input wire logic load,
	input wire logic [2:0] len,
	// Status
	output logic last
);

	logic [2:0] cnt_q;
	logic [2:0] cnt_d;

	// The counter reloads on load and otherwise counts down to one.
	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = len;
		end else if (cnt_q > 3'd1) begin
			cnt_d = cnt_q - 3'd1;
		end
		last = (cnt_q == 3'd1);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 3'd0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule : byte_alu_cycles
`default_nettype wire

// ===== dv/byte_alu_asserts.sv
// Port checker for the byte add/subtract datapath.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module byte_alu_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Watched outputs
	input wire logic code_take,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] acc_out,
	input wire logic [7:0] flags_out,
	input wire logic done,
	input wire logic busy
);
	// ----------------------------------------
	// Timing and flag relations
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// The strobe stands through all three states of a read cycle; data is taken in the third.
	sequence read_s;
		mem_rd [*3] ##1 !mem_rd;
	endsequence
	a_read_shape: assert property ($rose(mem_rd) |-> read_s)
		else $error("read strobe length wrong");
	a_addr_hold: assert property (mem_rd && $past(mem_rd) |-> $stable(mem_addr))
		else $error("address moved during read");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_take_pulse: assert property (code_take |=> !code_take)
		else $error("take longer than one cycle");
	a_sign_flag: assert property (done |-> flags_out[7] == acc_out[7])
		else $error("sign flag wrong");
	a_zero_flag: assert property (done |-> flags_out[6] == (acc_out == 8'h00))
		else $error("zero flag wrong");
	a_acc_still: assert property (!done |-> $stable(acc_out) && $stable(flags_out))
		else $error("result moved without done");
	a_done_cause: assert property ($rose(done) |-> $past(busy))
		else $error("done without busy");
	a_short_op: assert property ($rose(busy) |-> !done [*4])
		else $error("done before four states");
	a_long_op: assert property ($rose(busy) |-> ##[4:19] (done || !busy))
		else $error("done too late");
endmodule : byte_alu_asserts
bind byte_add_subtract_alu byte_alu_asserts i_byte_alu_asserts (.sys_clk, .rst, .code_take,
	.mem_rd, .mem_addr, .acc_out, .flags_out, .done, .busy);
`default_nettype wire

// ===== dv/byte_alu_mem_model.sv
// Operand memory model standing at the far side of the datapath.
// Assumes the bench fills it by hierarchical write before each read.
`timescale 1ns/1ps
`default_nettype none
module byte_alu_mem_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Operand read port
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	output logic [7:0] mem_data
);
	logic [7:0] mem [logic [15:0]];
	logic hold_q;
	logic [7:0] junk_q;
	// Data stands one state past the strobe; then the bus churns so stale reads show.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hold_q <= 1'b0;
			junk_q <= 8'h5a;
		end else begin
			hold_q <= mem_rd;
			junk_q <= {junk_q[6:0], ~junk_q[7]};
		end
	end
	// Unwritten places answer with the churn as well.
	always_comb begin
		mem_data = junk_q;
		if ((mem_rd || hold_q) && mem.exists(mem_addr)) mem_data = mem[mem_addr];
	end
endmodule : byte_alu_mem_model
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the byte add/subtract datapath.
// Assumes the design, its checker and the memory model compile first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic code_valid = 1'b0;
	logic [7:0] code_byte = 8'h00;
	logic [7:0] rg [8] = '{default: 8'h00};
	logic [15:0] first_index_pair = 16'hfff0;
	logic [15:0] second_index_pair = 16'h0008;
	logic code_take, mem_rd, done, busy;
	logic [15:0] mem_addr;
	logic [7:0] mem_data, acc_out, flags_out;
	logic [23:0] notes [$];
	logic [23:0] nt;
	logic [15:0] exp_addr = 16'h0000;
	logic [7:0] flg = 8'h00;
	int cyc = 0;
	int t0 = 0;
	int seed = 32'h0a20;
	int bad_count = 0;
	int checks_done = 0;

	byte_add_subtract_alu i_byte_add_subtract_alu (.sys_clk, .rst, .code_valid, .code_byte,
		.code_take, .reg_b(rg[0]), .reg_c(rg[1]), .reg_d(rg[2]), .reg_e(rg[3]), .reg_h(rg[4]),
		.reg_l(rg[5]), .first_index_pair, .second_index_pair, .mem_rd, .mem_addr,
		.mem_data, .acc_out, .flags_out, .done, .busy);
	byte_alu_mem_model i_byte_alu_mem_model (.sys_clk, .rst, .mem_rd, .mem_addr, .mem_data);

	// Clock and a free cycle count for latency figures.
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	// Expected byte result: {acc, S Z 0 H 0 PV N C}.
	function automatic logic [15:0] calc(input int op, input logic [7:0] a, input logic [7:0] b,
		input logic ci);
		logic [8:0] s;
		logic h, v, c;
		c = (op == 1) ? ci : 1'b0;
		if (op == 2) begin
			s = {1'b0, a} - {1'b0, b};
			h = a[3:0] < b[3:0];
			v = (a[7] != b[7]) && (s[7] != a[7]);
		end else begin
			s = a + b + c;
			h = (a[3:0] + b[3:0] + c) > 15;
			v = (a[7] == b[7]) && (s[7] != a[7]);
		end
		return {s[7:0], s[7], s[7:0] == 8'h00, 1'b0, h, 1'b0, v, op == 2, s[8]};
	endfunction : calc

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	// Offer bytes one by one, stepping on each take, then wait for the result.
	task automatic run(input logic [7:0] b [$], input logic [7:0] st, input logic [15:0] r);
		int i;
		i = 0;
		notes.push_back({st, r});
		t0 = cyc;
		code_valid <= 1'b1;
		code_byte <= b[0];
		while (i < b.size()) begin
			@(negedge sys_clk);
			if (code_take === 1'b1) begin
				i++;
				code_byte <= (i < b.size()) ? b[i] : ~b[i - 1];
			end
		end
		code_valid <= 1'b0;
		while (done !== 1'b1) @(negedge sys_clk);
		@(negedge sys_clk);
	endtask : run

	// Results are matched to the oldest note; latency is held to one offset over all forms.
	always @(negedge sys_clk) begin
		if (mem_rd === 1'b1) check("mem_addr", mem_addr, exp_addr);
		if (done === 1'b1) begin
			nt = notes.pop_front();
			check("acc_out", {8'h00, acc_out}, {8'h00, nt[15:8]});
			check("flags_out", {8'h00, flags_out}, {8'h00, nt[7:0]});
			// One idle start edge comes before the first fetch state of every form.
			check("latency", 16'(cyc - t0 - nt[23:16]), 16'h0001);
		end
	end

	// Cut a hang short after several times the expected run length.
	initial begin
		#125000;
		bad_count++;
		end_sim();
	end

	// Every operation against every operand form, with random operands.
	initial begin
		logic [7:0] n, d, st;
		logic [7:0] bb [$];
		logic [15:0] a, r;
		repeat (10) @(posedge sys_clk);
		@(negedge sys_clk);
		rst <= 1'b0;
		for (int op = 0; op < 3; op++) begin
			for (int f = 0; f < 12; f++) begin
				if (f == 6) continue;
				for (int k = 0; k < 6; k++) rg[k] = 8'($random(seed));
				n = 8'($random(seed));
				d = 8'($random(seed));
				a = (f == 10) ? first_index_pair : second_index_pair;
				a = (f == 9) ? {rg[4], rg[5]} : a + {{8{d[7]}}, d};
				if (f < 8) begin
					bb = '{{3'b100, 2'(op), 3'(f)}};
					n = rg[f];
					st = 8'h04;
				end else if (f == 8) begin
					bb = '{{3'b110, 2'(op), 3'b110}, n};
					st = 8'h07;
				end else if (f == 9) begin
					bb = '{{3'b100, 2'(op), 3'b110}};
					st = 8'h07;
				end else begin
					bb = '{(f == 10) ? 8'hdd : 8'hfd, {3'b100, 2'(op), 3'b110}, d};
					st = 8'h13;
				end
				if (f > 8) begin
					i_byte_alu_mem_model.mem[a] = n;
					exp_addr = a;
				end
				r = calc(op, rg[7], n, flg[0]);
				rg[7] = r[15:8];
				flg = r[7:0];
				run(bb, st, r);
			end
		end
		// Refused forms: an unknown opcode, then a prefix before a non-arithmetic byte.
		bb = '{8'h00, 8'hdd, 8'h00};
		code_valid <= 1'b1;
		foreach (bb[j]) begin
			code_byte <= bb[j];
			@(negedge sys_clk);
			while (code_take !== 1'b1) @(negedge sys_clk);
		end
		code_valid <= 1'b0;
		repeat (4) @(negedge sys_clk);
		check("acc_kept", {8'h00, acc_out}, {8'h00, rg[7]});
		check("flags_kept", {8'h00, flags_out}, {8'h00, flg});
		end_sim();
	end
endmodule : tb
`default_nettype wire
